/* hdl/rivm_params.svh */
// constants for the reset and interrupt vector map
`ifndef RIVM_PARAMS_SVH
`define RIVM_PARAMS_SVH

`define RIVM_ADDR_W          16
`define RIVM_IDX_W           5
`define RIVM_NUM_IRQ         30
`define RIVM_APP_RESET_ADDR  16'h0000
`define RIVM_TABLE_OFS       16'h0002
`define RIVM_SLOT_WORDS      16'h0002
`define RIVM_FIRST_IRQ_VEC   5'h02
`define RIVM_FUSE_PROGRAMMED 1'h0

`endif

/* hdl/rivm_pkg.sv */
// types shared by the vector map modules
`default_nettype none
`include "rivm_params.svh"

package rivm_pkg;

    typedef logic [`RIVM_ADDR_W-1:0] rivm_addr_t;
    typedef logic [`RIVM_IDX_W-1:0]  rivm_idx_t;

    typedef enum logic [1:0] {
        RIVM_ST_BOOT   = 2'h0,
        RIVM_ST_IDLE   = 2'h1,
        RIVM_ST_WAIT   = 2'h2,
        RIVM_ST_SETTLE = 2'h3
    } rivm_state_t;

endpackage : rivm_pkg
`default_nettype wire

/* hdl/rivm_prio_enc.sv */
// lowest-index-first priority encoder over the interrupt requests
`timescale 1ns/100ps
`default_nettype none
`include "rivm_params.svh"

module rivm_prio_enc
    import rivm_pkg::*;
(
    // request lines, bit 0 is the lowest vector number
    input  wire logic [`RIVM_NUM_IRQ-1:0] req,
    // result
    output logic                          found,
    output rivm_idx_t                     index
);

    // walk from the top down so the lowest set bit is written last
    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = `RIVM_NUM_IRQ - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                index = rivm_idx_t'(i);
            end
        end
    end

endmodule : rivm_prio_enc
`default_nettype wire

/* hdl/rivm_top.sv */
// reset and interrupt vector address generation for the core fetch logic
`timescale 1ns/100ps
`default_nettype none
`include "rivm_params.svh"

// Behaviour
// RULE_01 - With the boot fuse unprogrammed every reset starts at 0x0000.
// RULE_02 - External requests 0..2 are vectors 2..4 at 0x0002..0x0006.
// RULE_03 - Pin-change requests 0..3 are vectors 5..8 at 0x0008..0x000E.
// RULE_04 - Watchdog is vector 9 at 0x0010, counter 2 events 10..12.
// RULE_05 - Counter 1 capture, match A, match B, wrap are vectors 13..16.
// RULE_06 - Counter 0 match A, match B and wrap are vectors 17..19.
// RULE_07 - The serial peripheral transfer done is vector 20 at 0x0026.
// RULE_08 - Serial port 0 receive, buffer empty, transmit are 21..23.
// RULE_09 - Comparator, converter, nv data, two-wire, store are 24..28.
// RULE_10 - Serial port 1 receive, buffer empty, transmit are 29..31.
// RULE_11 - With the boot fuse programmed reset starts at the boot address.
// RULE_12 - With table select set each vector is boot start plus its offset.
// RULE_13 - Reset follows only the fuse and the table only the select bit.
// RULE_14 - Fuse value 1 means unprogrammed and value 0 means programmed.
// RULE_15 - Among pending requests the lowest vector number is served first.
// RULE_16 - Vector n sits at the base plus two times n minus one.
module rivm_top
    import rivm_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // static configuration
    input  wire logic       boot_reset_fuse,
    input  wire logic       vector_table_select,
    input  wire rivm_addr_t boot_reset_addr,
    // core handshake
    input  wire logic global_irq_enable,
    input  wire logic irq_accept,
    // external and pin-change requests
    input  wire logic ext_request_0,
    input  wire logic ext_request_1,
    input  wire logic ext_request_2,
    input  wire logic pin_change_request_0,
    input  wire logic pin_change_request_1,
    input  wire logic pin_change_request_2,
    input  wire logic pin_change_request_3,
    // watchdog and counters
    input  wire logic watchdog_timeout_irq,
    input  wire logic counter2_match_a_irq,
    input  wire logic counter2_match_b_irq,
    input  wire logic counter2_wrap_irq,
    input  wire logic counter1_capture_irq,
    input  wire logic counter1_match_a_irq,
    input  wire logic counter1_match_b_irq,
    input  wire logic counter1_wrap_irq,
    input  wire logic counter0_match_a_irq,
    input  wire logic counter0_match_b_irq,
    input  wire logic counter0_wrap_irq,
    // serial and miscellaneous peripherals
    input  wire logic spi_transfer_done_irq,
    input  wire logic serial0_receive_done_irq,
    input  wire logic serial0_tx_buffer_empty_irq,
    input  wire logic serial0_transmit_done_irq,
    input  wire logic analog_compare_irq,
    input  wire logic conversion_done_irq,
    input  wire logic nv_data_ready_irq,
    input  wire logic two_wire_irq,
    input  wire logic program_store_ready_irq,
    input  wire logic serial1_receive_done_irq,
    input  wire logic serial1_tx_buffer_empty_irq,
    input  wire logic serial1_transmit_done_irq,
    // reset vector toward the core
    output rivm_addr_t reset_addr_q,
    output logic       reset_fetch_q,
    // interrupt vector toward the core
    output logic       irq_pending_q,
    output rivm_addr_t irq_addr_q,
    output rivm_idx_t  irq_num_q,
    output logic       irq_taken_q
);

    // request word, priority result and the address path to the core
    logic [`RIVM_NUM_IRQ-1:0] req_vec;
    logic                     req_found;
    rivm_idx_t                req_index;
    rivm_addr_t               table_base;
    rivm_addr_t               slot_ofs;
    rivm_addr_t               vec_addr;
    rivm_state_t              state_q;

    // bit k of the request word is vector k plus two, in table order
    // a new source needs its own slot here and a wider encoder
    assign req_vec = {
        serial1_transmit_done_irq,       // vector 31, see RULE_10
        serial1_tx_buffer_empty_irq,     // vector 30, see RULE_10
        serial1_receive_done_irq,        // vector 29, see RULE_10
        program_store_ready_irq,         // vector 28, see RULE_09
        two_wire_irq,                    // vector 27, see RULE_09
        nv_data_ready_irq,               // vector 26, see RULE_09
        conversion_done_irq,             // vector 25, see RULE_09
        analog_compare_irq,              // vector 24, see RULE_09
        serial0_transmit_done_irq,       // vector 23, see RULE_08
        serial0_tx_buffer_empty_irq,     // vector 22, see RULE_08
        serial0_receive_done_irq,        // vector 21, see RULE_08
        spi_transfer_done_irq,           // vector 20, see RULE_07
        counter0_wrap_irq,               // vector 19, see RULE_06
        counter0_match_b_irq,            // vector 18, see RULE_06
        counter0_match_a_irq,            // vector 17, see RULE_06
        counter1_wrap_irq,               // vector 16, see RULE_05
        counter1_match_b_irq,            // vector 15, see RULE_05
        counter1_match_a_irq,            // vector 14, see RULE_05
        counter1_capture_irq,            // vector 13, see RULE_05
        counter2_wrap_irq,               // vector 12, see RULE_04
        counter2_match_b_irq,            // vector 11, see RULE_04
        counter2_match_a_irq,            // vector 10, see RULE_04
        watchdog_timeout_irq,            // vector 9, see RULE_04
        pin_change_request_3,            // vector 8, see RULE_03
        pin_change_request_2,            // vector 7, see RULE_03
        pin_change_request_1,            // vector 6, see RULE_03
        pin_change_request_0,            // vector 5, see RULE_03
        ext_request_2,                   // vector 4, see RULE_02
        ext_request_1,                   // vector 3, see RULE_02
        ext_request_0                    // vector 2, see RULE_02
    };

    // lowest vector number wins when several are pending
    // the encoder is plain logic; its winner is registered below
    rivm_prio_enc u_prio (
        .req   (req_vec),
        .found (req_found),             // see RULE_15
        .index (req_index)
    );

    // table start moves with the select bit only, never with the fuse
    always_comb begin
        if (vector_table_select) begin
            table_base = boot_reset_addr + `RIVM_TABLE_OFS; // see RULE_12
        end else begin
            table_base = `RIVM_APP_RESET_ADDR + `RIVM_TABLE_OFS; // see RULE_13
        end
    end

    // two words per slot; index 0 is vector 2, the first after reset
    assign slot_ofs = rivm_addr_t'(req_index) * `RIVM_SLOT_WORDS; // see RULE_16
    assign vec_addr = table_base + slot_ofs;

    // sequencer: announce reset vector once, then serve requests
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= RIVM_ST_BOOT;
        end else begin
            case (state_q)
                // first cycle after release announces the reset vector
                RIVM_ST_BOOT: begin
                    state_q <= RIVM_ST_IDLE;
                end
                // nothing new is taken while the core masks interrupts
                RIVM_ST_IDLE: begin
                    if (global_irq_enable && req_found) begin
                        state_q <= RIVM_ST_WAIT;
                    end
                end
                // the offer stands until the core takes it
                RIVM_ST_WAIT: begin
                    if (irq_accept) begin
                        state_q <= RIVM_ST_SETTLE;
                    end
                end
                // one spare cycle lets the source drop its flag first
                RIVM_ST_SETTLE: begin
                    state_q <= RIVM_ST_IDLE;
                end
                default: begin
                    state_q <= RIVM_ST_IDLE;
                end
            endcase
        end
    end

    // fuse is sampled after reset release, never loaded by the reset itself
    // limitation: a fuse change after release waits for the next reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reset_addr_q  <= `RIVM_APP_RESET_ADDR;
            reset_fetch_q <= 1'b0;
        end else if (state_q == RIVM_ST_BOOT) begin
            reset_fetch_q <= 1'b1;
            if (boot_reset_fuse == `RIVM_FUSE_PROGRAMMED) begin // see RULE_14
                reset_addr_q <= boot_reset_addr;     // see RULE_11
            end else begin
                reset_addr_q <= `RIVM_APP_RESET_ADDR; // see RULE_01
            end
        end else begin
            reset_fetch_q <= 1'b0;
        end
    end

    // latch the winning vector so it stays still while the core decides
    // select is taken with the vector, so moving the table while a
    // vector is offered cannot bend the address the core will fetch
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_pending_q <= 1'b0;
            irq_addr_q    <= `RIVM_APP_RESET_ADDR;
            irq_num_q     <= '0;
        end else if (state_q == RIVM_ST_IDLE) begin
            if (global_irq_enable && req_found) begin
                irq_pending_q <= 1'b1;
                irq_addr_q    <= vec_addr;                        // see RULE_15
                irq_num_q     <= req_index + `RIVM_FIRST_IRQ_VEC; // see RULE_16
            end
        end else if (state_q == RIVM_ST_WAIT && irq_accept) begin
            irq_pending_q <= 1'b0;
        end
    end

    // acknowledge pulse; the source clears its flag on it
    // this pulse is the only clear hint; sources drop their own flags
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_taken_q <= 1'b0;
        end else begin
            irq_taken_q <= (state_q == RIVM_ST_WAIT) && irq_accept;
        end
    end

endmodule : rivm_top
`default_nettype wire

/* tb/rivm_checker.sv */
// concurrent checks on the vector map ports
`timescale 1ns/100ps
`default_nettype none
module rivm_checker
    import rivm_pkg::*;
(
    // clock, reset and inputs
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       boot_reset_fuse,
    input wire logic       vector_table_select,
    input wire rivm_addr_t boot_reset_addr,
    input wire logic       global_irq_enable,
    input wire logic       irq_accept,
    input wire logic       ext_request_0,
    // outputs
    input wire rivm_addr_t reset_addr_q,
    input wire logic       reset_fetch_q,
    input wire logic       irq_pending_q,
    input wire rivm_addr_t irq_addr_q,
    input wire rivm_idx_t  irq_num_q,
    input wire logic       irq_taken_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // accept step, then one settle cycle where nothing is offered
    sequence taken_s; irq_taken_q && !irq_pending_q; endsequence
    sequence quiet_s; !irq_taken_q && !irq_pending_q; endsequence
    fetch_pulse_a: assert property (
        reset_fetch_q |=> !reset_fetch_q) else $error("long fetch");
    // fuse taken from the load edge, later changes must not leak in
    reset_addr_a: assert property (
        reset_fetch_q |-> reset_addr_q == ($past(boot_reset_fuse) ?
        16'h0000 : boot_reset_addr)) else $error("bad reset address");
    addr_hold_a: assert property (
        !reset_fetch_q |-> $stable(reset_addr_q))
        else $error("reset address moved");
    vec_addr_a: assert property (
        $rose(irq_pending_q) |-> irq_addr_q == ($past(vector_table_select)
        ? boot_reset_addr : 16'h0000) + {10'h000, irq_num_q, 1'b0} - 16'h0002)
        else $error("bad vector address");
    first_wins_a: assert property (
        $rose(irq_pending_q) && $past(ext_request_0) |-> irq_num_q == 5'h02)
        else $error("lowest not chosen");
    accept_step_a: assert property (
        irq_pending_q && irq_accept |=> taken_s ##1 quiet_s)
        else $error("bad accept step");
    latch_new_a: assert property (
        $past(nrst) && !reset_fetch_q && !irq_pending_q && !irq_taken_q &&
        !$past(irq_taken_q) && global_irq_enable && ext_request_0
        |=> irq_pending_q) else $error("request not offered");
    mask_hold_a: assert property (
        !global_irq_enable && !irq_pending_q |=> !irq_pending_q)
        else $error("masked request offered");
endmodule : rivm_checker
bind rivm_top rivm_checker chk_u (
    .clock               (clock),
    .nrst                (nrst),
    .boot_reset_fuse     (boot_reset_fuse),
    .vector_table_select (vector_table_select),
    .boot_reset_addr     (boot_reset_addr),
    .global_irq_enable   (global_irq_enable),
    .irq_accept          (irq_accept),
    .ext_request_0       (ext_request_0),
    .reset_addr_q        (reset_addr_q),
    .reset_fetch_q       (reset_fetch_q),
    .irq_pending_q       (irq_pending_q),
    .irq_addr_q          (irq_addr_q),
    .irq_num_q           (irq_num_q),
    .irq_taken_q         (irq_taken_q)
);
`default_nettype wire

/* tb/rivm_core_model.sv */
// core fetch model taking each offered vector after a set delay
`timescale 1ns/100ps
`default_nettype none
module rivm_core_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       nrst,
    // offer, chosen slowness and acceptance
    input  wire logic       irq_pending_q,
    input  wire logic [3:0] accept_delay,
    output logic            irq_accept
);
    logic [3:0] wait_q;
    // falling edge drive, accept held for one cycle only, then the count restarts
    always @(negedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 4'h0;
            irq_accept <= 1'b0;
        end else if (irq_pending_q && !irq_accept) begin
            irq_accept <= (wait_q == accept_delay);
            wait_q <= wait_q + 4'h1;
        end else begin
            irq_accept <= 1'b0;
            wait_q <= 4'h0;
        end
    end
endmodule : rivm_core_model
`default_nettype wire

/* tb/tb_top.sv */
// bench for the vector map with a core fetch model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        fuse = 1'b1;
    logic        sel = 1'b0;
    logic        gie = 1'b0;
    logic [15:0] baddr = 16'h7E00;
    logic [29:0] r = 30'h0;
    logic [3:0]  dly = 4'h0;
    logic        accept, fetch, pend, taken;
    logic [15:0] raddr, iaddr;
    logic [4:0]  inum;
    int          num_errors = 0;
    int          n_tests = 0;
    always #2.5 clock = ~clock;
    rivm_top dut_u (.clock(clock), .nrst(nrst), .boot_reset_fuse(fuse),
        .vector_table_select(sel), .boot_reset_addr(baddr),
        .global_irq_enable(gie), .irq_accept(accept), .ext_request_0(r[0]),
        .ext_request_1(r[1]), .ext_request_2(r[2]),
        .pin_change_request_0(r[3]), .pin_change_request_1(r[4]),
        .pin_change_request_2(r[5]), .pin_change_request_3(r[6]),
        .watchdog_timeout_irq(r[7]), .counter2_match_a_irq(r[8]),
        .counter2_match_b_irq(r[9]), .counter2_wrap_irq(r[10]),
        .counter1_capture_irq(r[11]), .counter1_match_a_irq(r[12]),
        .counter1_match_b_irq(r[13]), .counter1_wrap_irq(r[14]),
        .counter0_match_a_irq(r[15]), .counter0_match_b_irq(r[16]),
        .counter0_wrap_irq(r[17]), .spi_transfer_done_irq(r[18]),
        .serial0_receive_done_irq(r[19]), .serial0_tx_buffer_empty_irq(r[20]),
        .serial0_transmit_done_irq(r[21]), .analog_compare_irq(r[22]),
        .conversion_done_irq(r[23]), .nv_data_ready_irq(r[24]),
        .two_wire_irq(r[25]), .program_store_ready_irq(r[26]),
        .serial1_receive_done_irq(r[27]), .serial1_tx_buffer_empty_irq(r[28]),
        .serial1_transmit_done_irq(r[29]), .reset_addr_q(raddr),
        .reset_fetch_q(fetch), .irq_pending_q(pend), .irq_addr_q(iaddr),
        .irq_num_q(inum), .irq_taken_q(taken));
    rivm_core_model core_u (.clock(clock), .nrst(nrst),
        .irq_pending_q(pend), .accept_delay(dly), .irq_accept(accept));
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    // fuse flipped after the load edge must not move the reset vector
    task automatic t_reset(logic f);
        nrst = 1'b0;
        fuse = f;
        repeat (8) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        chk("fetch", 16'h0001, {15'h0000, fetch});
        chk("raddr", f ? 16'h0000 : baddr, raddr);
        fuse = ~f;
        @(negedge clock);
        chk("fetch end", 16'h0000, {15'h0000, fetch});
        chk("raddr held", f ? 16'h0000 : baddr, raddr);
        $display("reset test done, fuse %b", f);
    endtask : t_reset
    // every source raised at once: served in vector order, back to back
    task automatic t_sweep(logic s, logic [3:0] d);
        logic [15:0] base;
        base = s ? baddr + 16'h0002 : 16'h0002;
        sel = s;
        dly = d;
        r = 30'h3FFFFFFF;
        for (int i = 0; i < 30; i++) begin
            for (int k = 0; k < 40 && pend !== 1'b1; k++) @(negedge clock);
            chk("pend", 16'h0001, {15'h0000, pend});
            chk("num", 16'(i + 2), {11'h000, inum});
            chk("addr", base + 16'(2 * i), iaddr);
            for (int k = 0; k < 40 && taken !== 1'b1; k++) @(negedge clock);
            chk("taken", 16'h0001, {15'h0000, taken});
            r[i] = 1'b0;
        end
        $display("sweep test done, select %b", s);
    endtask : t_sweep
    // a masked request waits for the enable, then is offered at once
    task automatic t_mask;
        gie = 1'b0;
        r[4] = 1'b1;
        repeat (10) @(negedge clock);
        chk("masked", 16'h0000, {15'h0000, pend});
        gie = 1'b1;
        @(negedge clock);
        chk("offered", 16'h0001, {15'h0000, pend});
        chk("unmasked", 16'h0006, {11'h000, inum});
        chk("unmasked addr", (sel ? baddr : 16'h0000) + 16'h000A, iaddr);
        for (int k = 0; k < 40 && taken !== 1'b1; k++) @(negedge clock);
        chk("mask taken", 16'h0001, {15'h0000, taken});
        r[4] = 1'b0;
        $display("mask test done");
    endtask : t_mask
    initial begin
        t_reset(1'b1);
        gie = 1'b1;
        t_sweep(1'b0, 4'h0);
        t_sweep(1'b1, 4'h5);
        t_mask;
        t_reset(1'b0);
        t_sweep(1'b1, 4'h2);
        t_sweep(1'b0, 4'h1);
        summarize;
    end
    // about six times the expected run length of some 3200 ns
    initial begin
        #20000 num_errors++;
        summarize;
    end
endmodule : tb_top
`default_nettype wire
